// File: shared/cbu_pkg.sv
// Package: opcodes, field positions, widths and carrier structs
package cbu_pkg;

  localparam int XLEN = 64;

  // Instruction field positions
  localparam int OP_MSB     = 31;
  localparam int OP_LSB     = 26;
  localparam int RA_MSB     = 25;
  localparam int RA_LSB     = 21;
  localparam int RB_MSB     = 20;
  localparam int RB_LSB     = 16;
  localparam int OFS_MSB    = 15;
  localparam int SIGN32_BIT = 31;
  localparam int SIGN64_BIT = 63;

  // Opcodes and selectors
  localparam logic [5:0] OP_REG_IMM_GROUP   = 6'h01;
  localparam logic [5:0] OP_BRANCH_EQUAL    = 6'h04;
  localparam logic [5:0] OP_BRANCH_EQUAL_L  = 6'h14;
  localparam logic [5:0] OP_COPROC_SYS      = 6'h10;
  localparam logic [4:0] SUB_COPROC_BRANCH  = 5'h08;
  localparam logic [4:0] SEL_COND_TRUE      = 5'h01;
  localparam logic [4:0] SEL_COND_TRUE_L    = 5'h03;
  localparam logic [4:0] SEL_NONNEG         = 5'h01;
  localparam logic [4:0] SEL_NONNEG_L       = 5'h03;
  localparam logic [4:0] SEL_NONNEG_LINK    = 5'h11;
  localparam logic [4:0] SEL_NONNEG_LINK_L  = 5'h13;
  localparam logic [4:0] LINK_REGISTER      = 5'h1F;
  localparam logic [XLEN-1:0] LINK_OFFSET   = 64'h0000_0000_0000_0008;
  localparam logic [XLEN-1:0] SLOT_OFFSET   = 64'h0000_0000_0000_0004;
  localparam logic              COND_RESET  = 1'b0;

  // Decoded branch kind
  typedef enum logic [3:0] {
    CBU_K_NONE  = 4'h0,
    CBU_K_CPT   = 4'h1,
    CBU_K_CPTL  = 4'h2,
    CBU_K_EQ    = 4'h3,
    CBU_K_EQL   = 4'h4,
    CBU_K_NN    = 4'h5,
    CBU_K_NNL   = 4'h6,
    CBU_K_NNAL  = 4'h7,
    CBU_K_NNALL = 4'h8
  } cbu_kind_t;

  // Issue request from the pipeline
  typedef struct packed {
    logic            valid;
    logic [31:0]     instr;
    logic [XLEN-1:0] pc;
    logic [XLEN-1:0] src_a;
    logic [XLEN-1:0] src_b;
  } cbu_issue_t;

  // Decoder output
  typedef struct packed {
    cbu_kind_t kind;
    logic      likely;
    logic      link;
    logic      coproc;
  } cbu_dec_t;

  // Resolution results toward the pipeline
  typedef struct packed {
    logic            redirect;
    logic [XLEN-1:0] target;
    logic            nullify;
    logic            cop_unusable;
    logic            link_we;
    logic [4:0]      link_reg;
    logic [XLEN-1:0] link_data;
  } cbu_result_t;

  localparam int PC_W = XLEN;

endpackage : cbu_pkg

// File: src/cbu_decode.sv
// Branch instruction decoder
`timescale 1ns/1ps
module cbu_decode (
  // Instruction
  input  wire logic [31:0]      instr_i,
  // Decoded branch
  output cbu_pkg::cbu_dec_t     dec_o
);
  import cbu_pkg::*;

  logic [5:0] op;
  logic [4:0] ra;
  logic [4:0] rb;

  assign op = instr_i[OP_MSB:OP_LSB];
  assign ra = instr_i[RA_MSB:RA_LSB];
  assign rb = instr_i[RB_MSB:RB_LSB];

  always_comb begin
    dec_o = '{kind: CBU_K_NONE, likely: 1'b0, link: 1'b0, coproc: 1'b0};
    case (op)
      OP_COPROC_SYS: begin
        if (ra == SUB_COPROC_BRANCH) begin
          if (rb == SEL_COND_TRUE) begin
            dec_o.kind   = CBU_K_CPT;
            dec_o.coproc = 1'b1;
          end else if (rb == SEL_COND_TRUE_L) begin
            dec_o.kind   = CBU_K_CPTL;
            dec_o.coproc = 1'b1;
            dec_o.likely = 1'b1;
          end
        end
      end
      OP_BRANCH_EQUAL: dec_o.kind = CBU_K_EQ;
      OP_BRANCH_EQUAL_L: begin
        dec_o.kind   = CBU_K_EQL;
        dec_o.likely = 1'b1;
      end
      OP_REG_IMM_GROUP: begin
        case (rb)
          SEL_NONNEG: dec_o.kind = CBU_K_NN;
          SEL_NONNEG_L: begin
            dec_o.kind   = CBU_K_NNL;
            dec_o.likely = 1'b1;
          end
          SEL_NONNEG_LINK: begin
            dec_o.kind = CBU_K_NNAL;
            dec_o.link = 1'b1;
          end
          SEL_NONNEG_LINK_L: begin
            dec_o.kind   = CBU_K_NNALL;
            dec_o.link   = 1'b1;
            dec_o.likely = 1'b1;
          end
          default: dec_o.kind = CBU_K_NONE;
        endcase
      end
      default: dec_o.kind = CBU_K_NONE;
    endcase
  end

endmodule : cbu_decode

// File: src/cbu_branch_unit.sv
// Conditional branch unit: decode, resolve, delay slot handling, link
`timescale 1ns/1ps
// Overview of operation
// - Target is slot address plus sign-extended offset shifted left two.
// - A taken branch redirects only after the delay-slot instruction issues.
// - Untaken likely branches nullify their delay-slot instruction.
// - Coprocessor-true takes on true line; unusable exception if disabled.
// - Coprocessor condition is the line sampled at the previous instruction.
// - Coprocessor branch subop 01000 with selector 00001 decodes branch-true.
// - Selector 00011 under the coprocessor branch subop decodes likely form.
// - Branch-equal compares full source registers, taken only when identical.
// - Likely branch-equal takes when equal, else nullifies delay slot.
// - Opcode 000001 is the register-immediate group; second field selects.
// - Selectors 00001 and 00011 decode non-negative branch and likely form.
// - Selectors 10001 and 10011 decode the link forms.
// - Non-negative branches take when the source sign bit is clear.
// - Link forms write branch address plus eight to register 31 whatever the outcome, but not when issued in a delay slot.
// - Naming register 31 as source in a link form raises no exception.
module cbu_branch_unit (
  // Clock and reset
  input  wire logic              clk_sys_i,
  input  wire logic              rst_i,
  // Mode and coprocessor status
  input  wire logic              mode64_i,
  input  wire logic              coproc_usable_i,
  input  wire logic              coproc_condition_line_i,
  // Instruction issue
  input  cbu_pkg::cbu_issue_t    issue_i,
  // Resolution
  output cbu_pkg::cbu_result_t   result_o,
  output logic                   is_branch_o
);
  import cbu_pkg::*;

  typedef enum logic [1:0] {
    CBU_S_IDLE = 2'b01,
    CBU_S_SLOT = 2'b10
  } cbu_state_t;

  typedef struct packed {
    cbu_state_t      state;
    logic            cond_prev;
    logic            pend_take;
    logic            pend_null;
    logic [XLEN-1:0] pend_target;
    cbu_result_t     res;
  } cbu_regs_t;

  cbu_regs_t r;
  cbu_regs_t next_r;
  cbu_dec_t  dec;

  cbu_decode u_decode (
    .instr_i (issue_i.instr),
    .dec_o   (dec)
  );

  // Sign extension of the word-shifted offset, width chosen by mode
  function automatic logic [XLEN-1:0] branch_offset(
    input logic [15:0] ofs,
    input logic        m64
  );
    logic [XLEN-1:0] full;
    full = {{(XLEN-18){ofs[OFS_MSB]}}, ofs, 2'b00};
    if (!m64) begin
      full = {{32{full[SIGN32_BIT]}}, full[31:0]};
    end
    return full;
  endfunction : branch_offset

  // Sign test of the source operand in the active mode
  function automatic logic is_nonneg(
    input logic [XLEN-1:0] v,
    input logic            m64
  );
    return m64 ? ~v[SIGN64_BIT] : ~v[SIGN32_BIT];
  endfunction : is_nonneg

  logic            cond;
  logic            is_br;
  logic [XLEN-1:0] slot_pc;
  logic [XLEN-1:0] tgt;

  assign is_br       = issue_i.valid && (dec.kind != CBU_K_NONE);
  assign is_branch_o = is_br;
  assign slot_pc     = issue_i.pc + SLOT_OFFSET;
  assign tgt         = slot_pc + branch_offset(issue_i.instr[15:0],
                                               mode64_i);

  always_comb begin
    case (dec.kind)
      CBU_K_CPT, CBU_K_CPTL: cond = r.cond_prev;
      CBU_K_EQ, CBU_K_EQL:
        cond = (issue_i.src_a == issue_i.src_b);
      CBU_K_NN, CBU_K_NNL, CBU_K_NNAL, CBU_K_NNALL:
        cond = is_nonneg(issue_i.src_a, mode64_i);
      default:               cond = 1'b0;
    endcase
  end

  always_comb begin
    next_r = r;
    next_r.res.redirect     = 1'b0;
    next_r.res.nullify      = 1'b0;
    next_r.res.cop_unusable = 1'b0;
    next_r.res.link_we      = 1'b0;
    // Line as seen by each issued instruction, used by the one after it
    if (issue_i.valid) begin
      next_r.cond_prev = coproc_condition_line_i;
    end
    case (r.state)
      CBU_S_IDLE: begin
        if (is_br) begin
          if (dec.coproc && !coproc_usable_i) begin
            next_r.res.cop_unusable = 1'b1;
          end else begin
            next_r.pend_take   = cond;
            next_r.pend_null   = dec.likely && !cond;
            next_r.pend_target = tgt;
            next_r.state       = CBU_S_SLOT;
            if (dec.link) begin
              // Written regardless of outcome or source register
              next_r.res.link_we   = 1'b1;
              next_r.res.link_reg  = LINK_REGISTER;
              next_r.res.link_data = issue_i.pc + LINK_OFFSET;
            end
          end
        end
      end
      CBU_S_SLOT: begin
        // Resolve once the delay-slot instruction issues
        if (issue_i.valid) begin
          next_r.res.redirect = r.pend_take;
          next_r.res.target   = r.pend_target;
          next_r.res.nullify  = r.pend_null;
          next_r.state        = CBU_S_IDLE;
        end
      end
      default: next_r.state = CBU_S_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      r <= '{state: CBU_S_IDLE, cond_prev: COND_RESET, pend_take: 1'b0,
             pend_null: 1'b0, pend_target: '0, res: '0};
    end else begin
      r <= next_r;
    end
  end

  assign result_o = r.res;

  //////////////////////////////////////////////////////////////////////////
  // Assertions

  sequence s_slot_issue;
    r.state == CBU_S_SLOT && issue_i.valid;
  endsequence

  property p_redirect_after_slot;
    @(posedge clk_sys_i) disable iff (rst_i)
      result_o.redirect |-> $past(r.state) == CBU_S_SLOT
                            && $past(issue_i.valid);
  endproperty
  a_redirect_after_slot: assert property (p_redirect_after_slot)
    else $error("redirect without a delay-slot issue");

  property p_slot_nullify;
    @(posedge clk_sys_i) disable iff (rst_i)
      s_slot_issue |=> result_o.nullify == $past(r.pend_null);
  endproperty
  a_slot_nullify: assert property (p_slot_nullify)
    else $error("nullify does not match pending outcome");

  property p_null_excl;
    @(posedge clk_sys_i) disable iff (rst_i)
      !(result_o.nullify && result_o.redirect);
  endproperty
  a_null_excl: assert property (p_null_excl)
    else $error("taken branch nullified its slot");

  property p_link_data;
    @(posedge clk_sys_i) disable iff (rst_i)
      (r.state == CBU_S_IDLE && is_br && dec.link) |=>
        result_o.link_we && result_o.link_reg == LINK_REGISTER
        && result_o.link_data == $past(issue_i.pc) + LINK_OFFSET;
  endproperty
  a_link_data: assert property (p_link_data)
    else $error("link write missing or wrong");

  property p_cop_unusable;
    @(posedge clk_sys_i) disable iff (rst_i)
      (r.state == CBU_S_IDLE && is_br && dec.coproc && !coproc_usable_i)
        |=> result_o.cop_unusable ##1 !result_o.redirect;
  endproperty
  a_cop_unusable: assert property (p_cop_unusable)
    else $error("coprocessor unusable not raised");

  property p_target;
    @(posedge clk_sys_i) disable iff (rst_i)
      (r.state == CBU_S_IDLE && is_br && !dec.coproc) |=>
        r.pend_target == $past(issue_i.pc) + SLOT_OFFSET
          + {{(XLEN-18){$past(issue_i.instr[OFS_MSB])}},
             $past(issue_i.instr[15:0]), 2'b00};
  endproperty
  a_target: assert property (p_target)
    else $error("branch target wrong");

  property p_eq_take;
    @(posedge clk_sys_i) disable iff (rst_i)
      (r.state == CBU_S_IDLE && is_br && dec.kind == CBU_K_EQ) |=>
        r.pend_take == ($past(issue_i.src_a) == $past(issue_i.src_b));
  endproperty
  a_eq_take: assert property (p_eq_take)
    else $error("equal branch outcome wrong");

  property p_nonneg_sign;
    @(posedge clk_sys_i) disable iff (rst_i)
      (r.state == CBU_S_IDLE && is_br && dec.kind == CBU_K_NN && mode64_i)
        |=> r.pend_take == !$past(issue_i.src_a[SIGN64_BIT]);
  endproperty
  a_nonneg_sign: assert property (p_nonneg_sign)
    else $error("non-negative test wrong");

  sequence s_cop_issue;
    r.state == CBU_S_IDLE && is_br && dec.coproc && coproc_usable_i;
  endsequence

  sequence s_eq_equal_issue;
    r.state == CBU_S_IDLE && is_br && issue_i.src_a == issue_i.src_b
      && (dec.kind == CBU_K_EQ || dec.kind == CBU_K_EQL);
  endsequence

  // A coprocessor branch right behind an issue sees that issue's line
  property p_cond_sampled;
    @(posedge clk_sys_i) disable iff (rst_i)
      issue_i.valid ##1 s_cop_issue |=>
        r.pend_take == $past(coproc_condition_line_i, 2);
  endproperty
  a_cond_sampled: assert property (p_cond_sampled)
    else $error("coprocessor branch used the wrong line sample");

  property p_cop_blocked;
    @(posedge clk_sys_i) disable iff (rst_i)
      (r.state == CBU_S_IDLE && is_br && dec.coproc && !coproc_usable_i)
        |=> r.state == CBU_S_IDLE && !result_o.link_we;
  endproperty
  a_cop_blocked: assert property (p_cop_blocked)
    else $error("unusable coprocessor branch entered its delay slot");

  property p_cpt_decode;
    @(posedge clk_sys_i) disable iff (rst_i)
      (issue_i.instr[OP_MSB:OP_LSB] == OP_COPROC_SYS
       && issue_i.instr[RA_MSB:RA_LSB] == SUB_COPROC_BRANCH
       && issue_i.instr[RB_MSB:RB_LSB] == SEL_COND_TRUE)
        |-> dec.kind == CBU_K_CPT && dec.coproc && !dec.likely;
  endproperty
  a_cpt_decode: assert property (p_cpt_decode)
    else $error("coprocessor-true branch not decoded");

  property p_link_likely_decode;
    @(posedge clk_sys_i) disable iff (rst_i)
      (issue_i.instr[OP_MSB:OP_LSB] == OP_REG_IMM_GROUP
       && issue_i.instr[RB_MSB:RB_LSB] == SEL_NONNEG_LINK_L)
        |-> dec.kind == CBU_K_NNALL && dec.link && dec.likely;
  endproperty
  a_link_likely_decode: assert property (p_link_likely_decode)
    else $error("likely link branch not decoded");

  property p_eql_untaken;
    @(posedge clk_sys_i) disable iff (rst_i)
      (r.state == CBU_S_IDLE && is_br && dec.kind == CBU_K_EQL
       && issue_i.src_a != issue_i.src_b) |=> r.pend_null && !r.pend_take;
  endproperty
  a_eql_untaken: assert property (p_eql_untaken)
    else $error("untaken likely equal branch keeps its slot");

  property p_eq_taken;
    @(posedge clk_sys_i) disable iff (rst_i)
      s_eq_equal_issue |=> r.pend_take && !r.pend_null;
  endproperty
  a_eq_taken: assert property (p_eq_taken)
    else $error("taken equal branch would nullify its slot");

  property p_nonneg_32;
    @(posedge clk_sys_i) disable iff (rst_i)
      (r.state == CBU_S_IDLE && is_br && !mode64_i && !dec.coproc
       && issue_i.instr[OP_MSB:OP_LSB] == OP_REG_IMM_GROUP)
        |=> r.pend_take == !$past(issue_i.src_a[SIGN32_BIT]);
  endproperty
  a_nonneg_32: assert property (p_nonneg_32)
    else $error("32-bit sign test wrong");

  // No resolution may leak out while the slot is still awaited
  property p_slot_wait;
    @(posedge clk_sys_i) disable iff (rst_i)
      (r.state == CBU_S_SLOT && !issue_i.valid)
        |=> r.state == CBU_S_SLOT && !result_o.redirect && !result_o.nullify;
  endproperty
  a_slot_wait: assert property (p_slot_wait)
    else $error("branch resolved before its delay slot");

  property p_slot_release;
    @(posedge clk_sys_i) disable iff (rst_i)
      s_slot_issue |=> r.state == CBU_S_IDLE;
  endproperty
  a_slot_release: assert property (p_slot_release)
    else $error("delay slot not released");

  property p_plain_no_link;
    @(posedge clk_sys_i) disable iff (rst_i)
      (r.state == CBU_S_IDLE && is_br && !dec.link) |=> !result_o.link_we;
  endproperty
  a_plain_no_link: assert property (p_plain_no_link)
    else $error("link write from a non-link branch");

  property p_eq_walk;
    @(posedge clk_sys_i) disable iff (rst_i)
      s_eq_equal_issue ##1 s_slot_issue |=> result_o.redirect
        && result_o.target == $past(issue_i.pc, 2) + SLOT_OFFSET
           + {{(XLEN-18){$past(issue_i.instr[OFS_MSB], 2)}},
              $past(issue_i.instr[15:0], 2), 2'b00};
  endproperty
  a_eq_walk: assert property (p_eq_walk)
    else $error("equal branch did not reach its target");

endmodule : cbu_branch_unit

// File: testbench/cpu_conditional_branch_unit_tb_top.sv
// Self-checking random bench for the conditional branch unit
`timescale 1ns/1ps
module cpu_conditional_branch_unit_tb_top;
  import cbu_pkg::*;

  logic        clk_sys_i               = 1'b0;
  logic        rst_i                   = 1'b1;
  logic        mode64_i                = 1'b1;
  logic        coproc_usable_i         = 1'b1;
  logic        coproc_condition_line_i = 1'b0;
  cbu_issue_t  issue_i                 = '0;
  cbu_result_t result_o;
  logic        is_branch_o;
  int          err_total               = 0;
  int          check_count             = 0;
  int          cyc                     = 0;
  int          seed                    = 32'hA310;

  ////////////////////////////////////////////////////////////////////////////
  always #2 clk_sys_i = ~clk_sys_i;

  cbu_branch_unit cbu_branch_unit_inst (
    .clk_sys_i               (clk_sys_i),
    .rst_i                   (rst_i),
    .mode64_i                (mode64_i),
    .coproc_usable_i         (coproc_usable_i),
    .coproc_condition_line_i (coproc_condition_line_i),
    .issue_i                 (issue_i),
    .result_o                (result_o),
    .is_branch_o             (is_branch_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    if (err_total == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One issue slot, launched at a falling edge and held for one cycle
  task automatic drive(input logic v, input logic [31:0] ins,
                       input logic [63:0] pc, input logic [63:0] a,
                       input logic [63:0] b, input logic cnd);
    @(negedge clk_sys_i);
    issue_i.valid           = v;
    issue_i.instr           = ins;
    issue_i.pc              = pc;
    issue_i.src_a           = a;
    issue_i.src_b           = b;
    coproc_condition_line_i = cnd;
  endtask : drive

  // Kinds: 0 cp-true, 1 its likely, 2 equal, 3 its likely,
  // 4 non-negative, 5 likely, 6 link, 7 link likely
  function automatic logic [31:0] enc(input int k, input logic [4:0] ra,
                                      input logic [4:0] rb,
                                      input logic [15:0] ofs);
    case (k)
      0:       enc = {6'h10, 5'h08, 5'h01, ofs};
      1:       enc = {6'h10, 5'h08, 5'h03, ofs};
      2:       enc = {6'h04, ra, rb, ofs};
      3:       enc = {6'h14, ra, rb, ofs};
      4:       enc = {6'h01, ra, 5'h01, ofs};
      5:       enc = {6'h01, ra, 5'h03, ofs};
      6:       enc = {6'h01, ra, 5'h11, ofs};
      default: enc = {6'h01, ra, 5'h13, ofs};
    endcase
  endfunction : enc

  // Taken decision worked out from the documented conditions
  function automatic logic taken(input int k, input logic [63:0] a,
                                 input logic [63:0] b, input logic cp,
                                 input logic m);
    if (k < 2) taken = cp;
    else if (k < 4) taken = (a == b);
    else taken = !(m ? a[63] : a[31]);
  endfunction : taken

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      end_of_test();
    end
  end

  initial begin : main
    int          k;
    int          gap;
    logic        m, cp, tk, lk, unus;
    logic [15:0] ofs;
    logic [4:0]  ra;
    logic [31:0] r1, r2, sins;
    logic [63:0] pc, a, b;
    repeat (12) @(negedge clk_sys_i);
    rst_i = 1'b0;
    chk(result_o.redirect, 1'b0);
    chk(result_o.link_data, 64'h0);
    for (int i = 0; i < 320; i++) begin
      r1 = $random(seed);
      r2 = $random(seed);
      k = (i < 16) ? i % 8 : (r2[10:8]);
      m = (i < 16) ? (i >= 8) : r1[0];
      ofs = (i < 16) ? (i[0] ? 16'h8000 : 16'h7FFF) : r2[31:16];
      ra = (i % 5 == 0) ? 5'h1F : r1[7:3];
      pc = m ? {r2, r1} & ~64'h3 : {34'h0, r1[29:2], 2'b00};
      a = {$random(seed), $random(seed)};
      b = (r2[1:0] == 2'h0) ? a : (r2[1:0] == 2'h1) ?
          a ^ 64'h0000_0100_0000_0000 : {r1, r2};
      cp = r2[4];
      mode64_i = m;
      coproc_usable_i = (r2[6:5] != 2'h0);
      lk = (k >= 6);
      unus = (k < 2) && !coproc_usable_i;
      tk = taken(k, a, b, cp, m);
      // A link branch in the delay slot must not be acted on as a branch or write the link
      sins = (r1[13] && !unus) ? enc(6, ra, 5'h00, ofs) : 32'h0;
      if (i == 160) begin
        // Reset while a taken branch waits for its delay slot
        drive(1'b1, enc(2, ra, ra, ofs), pc, a, a, cp);
        drive(1'b0, 32'h0, 64'h0, a, a, cp);
        rst_i = 1'b1;
        repeat (2) @(negedge clk_sys_i);
        rst_i = 1'b0;
        chk(result_o.target, 64'h0);
        drive(1'b1, 32'h0, pc + 64'h4, a, a, cp);
        drive(1'b0, 32'h0, 64'h0, a, a, cp);
        chk(result_o.redirect, 1'b0);
      end
      // Condition flips at the branch itself, so only the earlier sample counts
      drive(1'b1, 32'h0, pc - 64'h4, a, b, cp);
      #1 chk(is_branch_o, 1'b0);
      drive(1'b1, enc(k, ra, r1[12:8], ofs), pc, a, b, ~cp);
      #1 chk(is_branch_o, 1'b1);
      gap = r2[3:2] % 3;
      // Branch-edge pulses stand one cycle: look before any idle cycle
      drive(gap == 0, (gap == 0) ? sins : 32'h0, pc + 64'h4, a, b, ~cp);
      chk(result_o.link_we, lk);
      chk(result_o.cop_unusable, unus);
      chk(result_o.redirect, 1'b0);
      if (lk) begin
        chk(result_o.link_reg, 5'h1F);
        chk(result_o.link_data, pc + 64'h8);
      end
      if (gap == 2) drive(1'b0, 32'h0, 64'h0, a, b, ~cp);
      if (gap != 0) drive(1'b1, sins, pc + 64'h4, a, b, ~cp);
      drive(1'b0, 32'h0, 64'h0, a, b, ~cp);
      chk(result_o.redirect, tk && !unus);
      chk(result_o.nullify, !unus && k[0] && !tk);
      chk(result_o.link_we, 1'b0);
      if (tk && !unus) begin
        chk(result_o.target,
            pc + 64'h4 + {{46{ofs[15]}}, ofs, 2'b00});
      end
    end
    end_of_test();
  end
endmodule : cpu_conditional_branch_unit_tb_top
